// File: hw/swdl_ctrl.sv
// Purpose: Sleep depth, wake pin, pin events and debug lock control
// Assumes: Firmware requests sleep and reports handler completion
// Notes: Register port with read data one cycle after the strobe
// Operation
// R1 - A locked debug port refuses every access except a full erase.
// R2 - The debug lock is off after reset.
// R3 - With sleep disabled no sleep mode is ever entered.
// R4 - The chosen sleep mode never goes deeper than the configured limit; a limit of 0 still gives mode 1 here.
// R5 - Asleep and not held awake, UART receive data is ignored.
// R6 - Asserting the enabled wake pin raises a wake interrupt.
// R7 - While the wake pin is held asserted no sleep mode is entered.
// R8 - The wake function sits on one pin, others give pin interrupts.
// R9 - A pin interrupt wakes from any mode, then sleep resumes if allowed.
// R10 - The host asserts the wake pin before sending and holds it.
// R11 - The host waits for the notification before sending a command.
// R12 - Wake pin assertion queues a pin-change notification for transmit.
// R13 - The host holds the wake pin until the first response byte.
// R14 - The wake pin is selected by port 0-1 and pin 0-7.
// R15 - The wake pin active level is high or low, high by default.
// R16 - The wake pin is synchronised before use.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "swdl_defines.svh"
module swdl_ctrl #(
   parameter int PORTS = 2,
   parameter int PINS = 8,
   parameter int ERASE_CYCLES = `SWDL_ERASE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [PORTS*PINS-1:0] gpio_in,
   input wire logic [PORTS*PINS-1:0] gpio_irq_en,
   input wire logic uart_rx_valid,
   input wire logic [7:0] uart_rx_data,
   output logic uart_rx_accept,
   output logic [7:0] uart_rx_out,
   output logic notify_req,
   input wire logic notify_ack,
   output logic cpu_wake_irq,
   output logic [1:0] power_mode,
   input wire logic dbg_req,
   input wire logic dbg_erase_req,
   output logic dbg_grant,
   output logic dbg_erase_busy
);
   localparam int N = PORTS * PINS;
   initial begin
      if (PORTS != 2 || PINS != 8 || ERASE_CYCLES < 1) begin
         $error("swdl_ctrl supports 2 ports of 8 pins only");
      end
   end

   function automatic logic [3:0] pin_index(input logic port,
                                           input logic [2:0] pin);
      pin_index = {port, pin};
   endfunction

   logic [31:0] cfg;
   logic [N-1:0] pin_evt;
   logic [N-1:0] gpio_s;
   logic [N-1:0] gpio_q;
   logic wake_raw;
   logic wake_act;
   logic wake_act_q;
   logic irq_pend;
   logic [31:0] erase_cnt;
   swdl_pkg::swdl_state_t state;
   swdl_pkg::swdl_state_t next_state;
   swdl_pkg::swdl_mode_t next_mode;
   swdl_pkg::swdl_mode_t req_mode;
   logic sleep_req;
   logic handler_done;
   logic erase_cmd;

   logic lock_en;
   logic sleep_en;
   logic [1:0] max_mode;
   logic wake_en;
   logic [3:0] wake_idx;
   logic wake_high;
   assign lock_en = cfg[`SWDL_CFG_LOCK];
   assign sleep_en = cfg[`SWDL_CFG_SLEEP_EN];
   assign max_mode = cfg[`SWDL_CFG_MAXMODE_LO +: 2];
   assign wake_en = cfg[`SWDL_CFG_WAKE_EN];
   assign wake_high = cfg[`SWDL_CFG_WAKE_HIGH];
   assign wake_idx = pin_index(cfg[`SWDL_CFG_WAKE_PORT], // R14
                               cfg[`SWDL_CFG_WAKE_PIN_LO +: 3]);

   swdl_sync #(
      .WIDTH(N)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(gpio_in),
      .dout(gpio_s)
   ); // R16

   // Selected pin at its active level
   assign wake_raw = wake_high ? gpio_s[wake_idx] : ~gpio_s[wake_idx]; // R15
   assign wake_act = wake_en & wake_raw; // R8

   logic wake_rise;
   assign wake_rise = wake_act & ~wake_act_q;

   // Command strobes
   logic cmd_wr;
   assign cmd_wr = reg_wr && reg_addr == `SWDL_ADDR_CMD;
   assign sleep_req = cmd_wr && reg_wdata[`SWDL_CMD_SLEEP];
   assign handler_done = cmd_wr && reg_wdata[`SWDL_CMD_HANDLER_DONE];
   assign erase_cmd = cmd_wr && reg_wdata[`SWDL_CMD_ERASE];
   assign req_mode = reg_wdata[5:4];

   // Configuration register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg <= `SWDL_CFG_RESET; // R2
      end else if (reg_wr && reg_addr == `SWDL_ADDR_CFG) begin
         cfg <= {22'h0, reg_wdata[9:0]};
      end
   end

   // Pin edge history
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gpio_q <= '0;
         wake_act_q <= 1'b0;
      end else begin
         gpio_q <= gpio_s;
         wake_act_q <= wake_act;
      end
   end

   // Ordinary pin-change events, sticky, set wins over clear
   logic [N-1:0] pin_chg;
   assign pin_chg = (gpio_s ^ gpio_q) & gpio_irq_en;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_evt <= '0;
      end else begin
         if (reg_wr && reg_addr == `SWDL_ADDR_PIN_EVT) begin
            pin_evt <= (pin_evt & ~reg_wdata[N-1:0]) | pin_chg;
         end else begin
            pin_evt <= pin_evt | pin_chg;
         end
      end
   end

   // Deepest mode allowed when entering sleep
   always_comb begin
      next_mode = req_mode;
      if (req_mode > max_mode) begin
         next_mode = max_mode; // R4
      end
      if (next_mode == 2'h0) begin
         next_mode = 2'h1;
      end
   end

   logic any_irq;
   assign any_irq = wake_rise | (|pin_chg);

   // Power state machine
   always_comb begin
      next_state = state;
      case (state)
         swdl_pkg::SWDL_AWAKE: begin
            // R3 R7 R9
            if (sleep_req && sleep_en && !wake_act && !any_irq) begin
               next_state = swdl_pkg::SWDL_SLEEP;
            end
         end
         swdl_pkg::SWDL_SLEEP: begin
            if (wake_act) begin
               next_state = swdl_pkg::SWDL_AWAKE; // R6 R7
            end else if (|pin_chg) begin
               next_state = swdl_pkg::SWDL_HANDLER; // R9
            end
         end
         swdl_pkg::SWDL_HANDLER: begin
            if (handler_done) begin
               next_state = swdl_pkg::SWDL_WAKING;
            end
         end
         swdl_pkg::SWDL_WAKING: begin
            // Handler over, resume sleep only if still allowed
            if (sleep_en && !wake_act && !any_irq) begin
               next_state = swdl_pkg::SWDL_SLEEP; // R9
            end else begin
               next_state = swdl_pkg::SWDL_AWAKE;
            end
         end
         default: begin
            next_state = swdl_pkg::SWDL_AWAKE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= swdl_pkg::SWDL_AWAKE;
      end else begin
         state <= next_state;
      end
   end

   // Power mode output, sleep mode latched on entry
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         power_mode <= 2'h0;
      end else if (next_state != swdl_pkg::SWDL_SLEEP) begin
         power_mode <= 2'h0;
      end else if (state != swdl_pkg::SWDL_SLEEP) begin
         if (state == swdl_pkg::SWDL_AWAKE) begin
            power_mode <= next_mode; // R4
         end else begin
            power_mode <= max_mode == 2'h0 ? 2'h1 : max_mode; // R4
         end
      end
   end

   // Wake interrupt pulse to the processor
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_wake_irq <= 1'b0;
         irq_pend <= 1'b0;
      end else begin
         cpu_wake_irq <= wake_rise | (|pin_chg); // R6 R9
         irq_pend <= irq_pend | wake_rise;
      end
   end

   // Pin-change notification request, held until taken
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         notify_req <= 1'b0;
      end else if (wake_rise) begin
         notify_req <= 1'b1; // R12
      end else if (notify_ack) begin
         notify_req <= 1'b0;
      end
   end

   // UART receive gating
   logic rx_open;
   assign rx_open = state == swdl_pkg::SWDL_AWAKE || wake_act;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         uart_rx_accept <= 1'b0;
         uart_rx_out <= 8'h00;
      end else begin
         uart_rx_accept <= uart_rx_valid && rx_open; // R5 R10
         if (uart_rx_valid && rx_open) begin
            uart_rx_out <= uart_rx_data;
         end
      end
   end

   // Debug port gate and full erase sequence
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dbg_grant <= 1'b0;
      end else begin
         dbg_grant <= dbg_req && !lock_en && !dbg_erase_busy; // R1
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dbg_erase_busy <= 1'b0;
         erase_cnt <= 32'h0;
      end else if (dbg_erase_busy) begin
         if (erase_cnt == 32'(ERASE_CYCLES - 1)) begin
            dbg_erase_busy <= 1'b0;
            erase_cnt <= 32'h0;
         end else begin
            erase_cnt <= erase_cnt + 32'h1;
         end
      end else if (dbg_erase_req || erase_cmd) begin
         dbg_erase_busy <= 1'b1; // R1
      end
   end

   // Register read port
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            `SWDL_ADDR_CFG: reg_rdata <= cfg;
            `SWDL_ADDR_STATUS: begin
               reg_rdata <= {22'h0, dbg_erase_busy, irq_pend, notify_req,
                             wake_act, power_mode, state};
            end
            `SWDL_ADDR_PIN_EVT: reg_rdata <= {16'h0, pin_evt};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end
endmodule // swdl_ctrl
`default_nettype wire

// File: hw/swdl_defines.svh
// Purpose: Constants for the sleep, wake and debug lock controller
// Assumes: Included by bare name
// Notes: Register offsets are byte addresses of 32-bit words
`ifndef SWDL_DEFINES_SVH
`define SWDL_DEFINES_SVH
`define SWDL_ADDR_CFG 8'h00
`define SWDL_ADDR_STATUS 8'h04
`define SWDL_ADDR_PIN_EVT 8'h08
`define SWDL_ADDR_CMD 8'h0c
`define SWDL_CFG_LOCK 0
`define SWDL_CFG_SLEEP_EN 1
`define SWDL_CFG_MAXMODE_LO 2
`define SWDL_CFG_WAKE_EN 4
`define SWDL_CFG_WAKE_PORT 5
`define SWDL_CFG_WAKE_PIN_LO 6
`define SWDL_CFG_WAKE_HIGH 9
`define SWDL_CFG_RESET 32'h0000_020c
`define SWDL_CMD_SLEEP 0
`define SWDL_CMD_HANDLER_DONE 1
`define SWDL_CMD_ERASE 2
`define SWDL_ERASE_NS 1000
`define SWDL_ERASE_CYCLES ((`SWDL_ERASE_NS + 3) / 4)
`endif

// File: hw/swdl_pkg.sv
// Purpose: Types for the sleep, wake and debug lock controller
// Assumes: Nothing
// Notes: Power modes 0 to 3, 0 is fully awake
package swdl_pkg;
   typedef enum logic [3:0] {
      SWDL_AWAKE = 4'h1,
      SWDL_SLEEP = 4'h2,
      SWDL_HANDLER = 4'h4,
      SWDL_WAKING = 4'h8
   } swdl_state_t;
   typedef logic [1:0] swdl_mode_t;
endpackage

// File: hw/swdl_sync.sv
// Purpose: Three-stage pin synchroniser with agreement check
// Assumes: Input is asynchronous to sys_clk
// Notes: Output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module swdl_sync #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   initial begin
      if (WIDTH < 1) begin
         $error("swdl_sync width must be positive");
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_agree
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               dout[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule // swdl_sync
`default_nettype wire

// File: testbench/swdl_ctrl_asserts.sv
// Purpose: Port checks for swdl_ctrl
// Assumes: Sync reset rst
// Notes: Bound into every swdl_ctrl
`timescale 1ns/1ps
`default_nettype none
module swdl_ctrl_asserts #(
   parameter int ERASE_CYCLES = 250
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic uart_rx_valid,
   input wire logic [7:0] uart_rx_data,
   input wire logic uart_rx_accept,
   input wire logic [7:0] uart_rx_out,
   input wire logic notify_req,
   input wire logic notify_ack,
   input wire logic cpu_wake_irq,
   input wire logic [1:0] power_mode,
   input wire logic dbg_req,
   input wire logic dbg_erase_req,
   input wire logic dbg_grant,
   input wire logic dbg_erase_busy
);
   int busy_n;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge sys_clk) begin
      busy_n <= (rst || !dbg_erase_busy) ? 0 : busy_n + 1;
   end
   property p_grant;
      dbg_grant |-> $past(dbg_req) && !$past(dbg_erase_busy);
   endproperty
   a_grant: assert property (p_grant) else $error("bad grant");
   property p_erase_go;
      $rose(dbg_erase_busy) |-> $past(dbg_erase_req);
   endproperty
   a_erase_go: assert property (p_erase_go) else $error("bad erase");
   property p_erase_len;
      $fell(dbg_erase_busy) |-> busy_n == ERASE_CYCLES;
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase len");
   property p_rx;
      uart_rx_accept |-> $past(uart_rx_valid)
         && uart_rx_out == $past(uart_rx_data);
   endproperty
   a_rx: assert property (p_rx) else $error("bad rx byte");
   property p_wake;
      cpu_wake_irq |-> ##[0:2] power_mode == 2'h0;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_ntf_irq;
      $rose(notify_req) |-> cpu_wake_irq;
   endproperty
   a_ntf_irq: assert property (p_ntf_irq) else $error("notify alone");
   property p_ntf_hold;
      notify_req && !notify_ack |=> notify_req;
   endproperty
   a_ntf_hold: assert property (p_ntf_hold) else $error("notify lost");
   property p_ntf_clr;
      $fell(notify_req) |-> $past(notify_ack);
   endproperty
   a_ntf_clr: assert property (p_ntf_clr) else $error("notify drop");
endmodule // swdl_ctrl_asserts
bind swdl_ctrl swdl_ctrl_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_asserts (
   .sys_clk(sys_clk), .rst(rst), .uart_rx_valid(uart_rx_valid),
   .uart_rx_data(uart_rx_data), .uart_rx_accept(uart_rx_accept),
   .uart_rx_out(uart_rx_out), .notify_req(notify_req),
   .notify_ack(notify_ack), .cpu_wake_irq(cpu_wake_irq),
   .power_mode(power_mode), .dbg_req(dbg_req),
   .dbg_erase_req(dbg_erase_req), .dbg_grant(dbg_grant),
   .dbg_erase_busy(dbg_erase_busy));
`default_nettype wire

// File: testbench/swdl_host_model.sv
// Purpose: Host driving the wake pin and UART bytes
// Assumes: Wake pin on port 0 pin 0, active high
// Notes: rude sends bytes without the wake pin
`timescale 1ns/1ps
`default_nettype none
module swdl_host_model (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic rude,
   input wire logic [7:0] gap,
   input wire logic notify_req,
   input wire logic uart_rx_accept,
   output logic wake_pin,
   output logic uart_rx_valid,
   output logic [7:0] uart_rx_data,
   output logic notify_ack,
   output logic host_busy,
   output logic [7:0] n_acc
);
   always @(posedge sys_clk) n_acc <= n_acc + {7'h0, uart_rx_accept};
   initial begin
      {wake_pin, uart_rx_valid, notify_ack, host_busy} = 4'h0;
      uart_rx_data = 8'h00;
      n_acc = 8'h00;
      forever begin
         @(posedge sys_clk);
         if (go) begin
            host_busy <= 1'b1;
            if (!rude) begin
               wake_pin <= 1'b1;
               for (int i = 0; i < 50; i++) begin
                  if (notify_req !== 1'b1) @(posedge sys_clk);
               end
               notify_ack <= 1'b1;
               @(posedge sys_clk);
               notify_ack <= 1'b0;
            end
            for (int i = 0; i < 3; i++) begin
               if (gap != 8'h00) begin
                  uart_rx_valid <= 1'b0;
                  repeat (gap) @(posedge sys_clk);
               end
               uart_rx_valid <= 1'b1;
               uart_rx_data <= 8'h51 + 8'(i);
               @(posedge sys_clk);
            end
            uart_rx_valid <= 1'b0;
            repeat (4) @(posedge sys_clk);
            wake_pin <= 1'b0;
            host_busy <= 1'b0;
         end
      end
   end
endmodule // swdl_host_model
`default_nettype wire

// File: testbench/test_sleep_wake_and_debug_lock_control.sv
// Purpose: Bench for the sleep, wake and debug lock controller
// Assumes: Erase shortened to 4 cycles
// Notes: Host model owns the wake pin and UART input
`timescale 1ns/1ps
`default_nettype none
`include "swdl_defines.svh"
module test_sleep_wake_and_debug_lock_control;
   logic sys_clk, rst, reg_wr, reg_rd, dbg_req, dbg_erase_req, go, rude;
   logic uart_rx_valid, uart_rx_accept, notify_req, notify_ack, wake_pin;
   logic cpu_wake_irq, dbg_grant, dbg_erase_busy, host_busy;
   logic [7:0] reg_addr, uart_rx_data, uart_rx_out, gap, n_acc;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [15:0] pins, irq_en;
   logic [1:0] power_mode;
   int bad_count, n_checks, n;
   swdl_ctrl #(.ERASE_CYCLES(4)) dut (.sys_clk(sys_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .gpio_in({pins[15:1], wake_pin}), .gpio_irq_en(irq_en),
      .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data),
      .uart_rx_accept(uart_rx_accept), .uart_rx_out(uart_rx_out),
      .notify_req(notify_req), .notify_ack(notify_ack),
      .cpu_wake_irq(cpu_wake_irq), .power_mode(power_mode),
      .dbg_req(dbg_req), .dbg_erase_req(dbg_erase_req),
      .dbg_grant(dbg_grant), .dbg_erase_busy(dbg_erase_busy));
   swdl_host_model host (.sys_clk(sys_clk), .go(go), .rude(rude),
      .gap(gap), .notify_req(notify_req), .uart_rx_accept(uart_rx_accept),
      .wake_pin(wake_pin), .uart_rx_valid(uart_rx_valid),
      .uart_rx_data(uart_rx_data), .notify_ack(notify_ack),
      .host_busy(host_busy), .n_acc(n_acc));
   task automatic chk(input string w, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic mode_is(input logic [1:0] e);
      for (int i = 0; i < 20 && power_mode !== e; i++) @(posedge sys_clk);
      chk("power mode", {30'h0, e}, {30'h0, power_mode});
   endtask
   task automatic host_run(input logic r, input logic [7:0] g);
      @(posedge sys_clk);
      {rude, gap, go} <= {r, g, 1'b1};
      cyc(1);
      go <= 1'b0;
      cyc(1);
   endtask
   task automatic host_wait;
      for (int i = 0; i < 200 && host_busy !== 1'b0; i++) @(posedge sys_clk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_reset;
      rd(`SWDL_ADDR_CFG);
      chk("cfg", `SWDL_CFG_RESET, v);
      rd(`SWDL_ADDR_STATUS);
      chk("state", 32'h1, {28'h0, v[3:0]});
      rd(8'h10);
      chk("unmapped", 32'h0, v);
      @(posedge sys_clk);
      dbg_req <= 1'b1;
      cyc(2);
      #1 chk("grant", 32'h1, {31'h0, dbg_grant});
      $display("test reset done");
   endtask
   task automatic t_lock;
      wr(`SWDL_ADDR_CFG, 32'h20d);
      cyc(2);
      #1 chk("locked grant", 32'h0, {31'h0, dbg_grant});
      @(posedge sys_clk);
      dbg_erase_req <= 1'b1;
      @(posedge sys_clk);
      dbg_erase_req <= 1'b0;
      n = 0;
      repeat (10) begin
         #1 n += int'(dbg_erase_busy === 1'b1);
         @(posedge sys_clk);
      end
      chk("erase cycles", 32'd4, n);
      wr(`SWDL_ADDR_CFG, `SWDL_CFG_RESET);
      cyc(2);
      #1 chk("open grant", 32'h1, {31'h0, dbg_grant});
      $display("test lock done");
   endtask
   task automatic t_sleep;
      wr(`SWDL_ADDR_CFG, 32'h20a);
      irq_en <= 16'h0020;
      wr(`SWDL_ADDR_CMD, 32'h31);
      mode_is(2'h2);
      host_run(1'b1, 8'h00);
      host_wait();
      chk("dropped bytes", 32'h0, {24'h0, n_acc});
      pins[5] <= 1'b1;
      mode_is(2'h0);
      rd(`SWDL_ADDR_PIN_EVT);
      chk("pin event", 32'h20, v & 32'h20);
      wr(`SWDL_ADDR_CMD, 32'h2);
      mode_is(2'h2);
      wr(`SWDL_ADDR_CFG, 32'h208);
      pins[5] <= 1'b0;
      mode_is(2'h0);
      wr(`SWDL_ADDR_CMD, 32'h2);
      mode_is(2'h0);
      wr(`SWDL_ADDR_CMD, 32'h31);
      cyc(5);
      chk("no sleep", 32'h0, {30'h0, power_mode});
      $display("test sleep done");
   endtask
   task automatic t_wake;
      wr(`SWDL_ADDR_CFG, 32'h216);
      wr(`SWDL_ADDR_CMD, 32'h11);
      mode_is(2'h1);
      host_run(1'b0, 8'h04);
      for (int i = 0; i < 50 && notify_req !== 1'b1; i++) @(posedge sys_clk);
      chk("notify", 32'h1, {31'h0, notify_req});
      mode_is(2'h0);
      wr(`SWDL_ADDR_CMD, 32'h11);
      cyc(3);
      chk("held awake", 32'h0, {30'h0, power_mode});
      host_wait();
      chk("bytes taken", 32'h3, {24'h0, n_acc});
      cyc(6);
      wr(`SWDL_ADDR_CMD, 32'h11);
      mode_is(2'h1);
      $display("test wake done");
   endtask
   task automatic t_pinsel;
      pins[11] <= 1'b1;
      cyc(6);
      wr(`SWDL_ADDR_CFG, 32'hf6);
      pins[11] <= 1'b0;
      mode_is(2'h0);
      rd(`SWDL_ADDR_STATUS);
      chk("wake active", 32'h1, {31'h0, v[6]});
      wr(`SWDL_ADDR_CMD, 32'h11);
      cyc(3);
      chk("low held", 32'h0, {30'h0, power_mode});
      $display("test pin select done");
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      bad_count++;
      test_done();
   end
   initial begin
      {rst, reg_wr, reg_rd, dbg_req, dbg_erase_req, go, rude} = 7'h40;
      {reg_addr, gap, pins, irq_en, reg_wdata} = 72'h0;
      cyc(20);
      rst <= 1'b0;
      t_reset();
      t_lock();
      t_sleep();
      t_wake();
      t_pinsel();
      test_done();
   end
endmodule // test_sleep_wake_and_debug_lock_control
`default_nettype wire
